// >>> ext_bus_pkg.sv
/*
 * Shared constants and types for the external multiplexed bus port.
 * Assumes a single 250 MHz core clock; no software-visible registers.
 */
package ext_bus_pkg;
    // Port width codes driven on port_width_code
    localparam logic [1:0] PW_32 = 2'h0;
    localparam logic [1:0] PW_8 = 2'h1;
    localparam logic [1:0] PW_16 = 2'h2;
    localparam logic [1:0] PW_BOOT_DEFAULT = 2'h0;
    // Access size codes on the request port
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h0;
    // Request target classes
    localparam logic [1:0] TGT_EXT = 2'h0;
    localparam logic [1:0] TGT_PERIPH = 2'h1;
    localparam logic [1:0] TGT_SRAM = 2'h2;
    localparam logic [1:0] TGT_CACHE = 2'h3;
    localparam int NUM_CS = 4;
    localparam logic [3:0] LANES_NONE = 4'hf;
    localparam logic [3:0] CS_NONE = 4'hf;
    // Bus clock is core clock divided by four
    localparam int CORE_PER_BUS_CLK = 4;
    localparam logic [1:0] DIV_RESET = 2'h0;
    // Bus phases, gray coded along idle-addr-data-done
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b11,
        PH_END = 2'b10
    } phase_e;
endpackage

// >>> cs_cfg_if.sv
/*
 * Carrier between the bus port and its per-chip-select width store.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface cs_cfg_if;
    logic [1:0] rd_sel;
    logic [1:0] rd_width;
    logic wr_en;
    logic [1:0] wr_sel;
    logic [1:0] wr_width;
    modport store (input rd_sel, input wr_en, input wr_sel, input wr_width, output rd_width);
    modport user (output rd_sel, output wr_en, output wr_sel, output wr_width, input rd_width);
endinterface

// >>> cs_width_store.sv
/*
 * Per-chip-select port width store, registered read data.
 * Assumes the boot strap width is applied to chip select 0 after reset.
 */
`timescale 1ns/1ps
module cs_width_store
    import ext_bus_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Strap sampled once released
    input wire logic [1:0] boot_width,
    cs_cfg_if.store cfg
);
    typedef struct packed {
        logic [NUM_CS-1:0][1:0] width;
        logic [1:0] rd;
        logic strapped;
    } st_s;
    st_s st_r, st_nxt;

    // Table update, strap capture and registered read
    always_comb begin
        st_nxt = st_r;
        if (!st_r.strapped) begin
            st_nxt.width[0] = boot_width; // RULE9
            st_nxt.strapped = 1'b1;
        end else if (cfg.wr_en) begin
            st_nxt.width[cfg.wr_sel] = cfg.wr_width;
        end
        st_nxt.rd = st_r.width[cfg.rd_sel];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg.rd_width = st_r.rd;
endmodule

// >>> ext_bus_port.sv
/*
 * External multiplexed address/data bus master port.
 * Assumes requests synchronous to the 250 MHz core clock; the bus phases
 * advance on the divided bus clock that is also driven out.
 */
// Overview of operation
// (RULE1) Address then data share one 32-bit two-way path, released when not driven.
// (RULE2) Byte-lane selects go low only for lanes the access uses.
// (RULE3) Lane select 0 is the top data byte and lane select 3 the bottom one.
// (RULE4) Lane selects assert for external and on-chip peripheral targets, never SRAM or cache.
// (RULE5) Read drive enable marks when the slave may drive data in a read.
// (RULE6) The slave's acknowledge ends the cycle; on a read the data is captured then.
// (RULE7) Direction output is high for reads and low for writes.
// (RULE8) A two-bit code gives the 8, 16 or 32 bit width of the chip select used.
// (RULE9) The boot chip select width comes from the strapped width code.
// (RULE10) The burst flag asserts for burst accesses.
// (RULE11) Transfer start marks the beginning of every transfer.
// (RULE12) Address latch strobe lasts exactly one bus clock at transaction start.
// (RULE13) External logic latches the address with the address latch strobe.
// (RULE14) Four chip selects each pick one external device.
// (RULE15) Bus clock out runs at a quarter of the core clock.
// (RULE16) Selects, drive enable and transfer start stay negated while idle.
`timescale 1ns/1ps
module ext_bus_port
    import ext_bus_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Boot strap and width programming
    input wire logic [1:0] boot_width,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [1:0] cfg_width,
    // Request side
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic req_read,
    input wire logic [1:0] req_size,
    input wire logic [1:0] req_cs,
    input wire logic [1:0] req_target,
    input wire logic req_burst,
    output logic req_ready,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // External bus pins
    output logic ext_bus_clk_out,
    input wire logic [31:0] mux_addr_data_bus_in,
    output logic [31:0] mux_addr_data_bus_out,
    output logic mux_addr_data_bus_oe,
    output logic [3:0] byte_lane_select_n,
    output logic read_drive_enable_n,
    input wire logic transfer_ack_n,
    output logic read_not_write,
    output logic [1:0] port_width_code,
    output logic burst_flag_n,
    output logic transfer_start_n,
    output logic addr_latch_strobe,
    output logic [3:0] chip_sel_n
);
    typedef struct packed {
        phase_e ph;
        logic [1:0] div;
        logic bclk;
        logic [31:0] ad_out;
        logic [31:0] wdata;
        logic ad_oe;
        logic [3:0] lanes_n;
        logic [3:0] lanes_hold;
        logic oe_n;
        logic rnw;
        logic is_rd;
        logic burst_n;
        logic ts_n;
        logic ale;
        logic [3:0] cs_n;
        logic [3:0] cs_hold;
        logic use_lanes;
        logic ready;
        logic rsp_v;
        logic [31:0] rdata;
        logic [1:0] pw;
    } st_s;
    st_s st_r, st_nxt;
    cs_cfg_if cfg ();

    // Lane pattern for size and low address, lane 0 being bits 31:24
    function automatic logic [3:0] lane_mask_n(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] m;
        m = 4'hf;
        case (sz)
            SZ_BYTE: m[a] = 1'b0; // RULE3
            SZ_WORD: m = a[1] ? 4'h3 : 4'hc; // RULE3
            default: m = 4'h0;
        endcase
        return m; // RULE2
    endfunction

    // One-hot active-low select from the chip select index
    function automatic logic [3:0] cs_decode_n(input logic [1:0] idx);
        logic [3:0] m;
        m = CS_NONE;
        m[idx] = 1'b0;
        return m;
    endfunction

    cs_width_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .boot_width(boot_width),
        .cfg(cfg.store)
    );
    assign cfg.wr_en = cfg_wr;
    assign cfg.wr_sel = cfg_sel;
    assign cfg.wr_width = cfg_width;
    assign cfg.rd_sel = req_cs;

    // Bus clock divider and phase sequencer; phases move only at bus clock rise
    always_comb begin
        logic rise;
        logic fall;
        st_nxt = st_r;
        rise = (st_r.div == 2'h1);
        fall = (st_r.div == 2'h3);
        st_nxt.div = st_r.div + 2'h1;
        st_nxt.rsp_v = 1'b0;
        // Width code frozen during a transfer so the slave sees one width
        if (st_r.ph == PH_IDLE) begin
            st_nxt.pw = cfg.rd_width; // RULE8
        end
        if (rise) begin
            st_nxt.bclk = 1'b1; // RULE15
        end
        if (fall) begin
            st_nxt.bclk = 1'b0; // RULE15
        end
        if (rise) begin
            case (st_r.ph)
                PH_IDLE: begin
                    // Width lookup is one cycle behind req_cs; the start does not wait for it to settle
                    if (req_valid && st_r.ready) begin
                        st_nxt.ph = PH_ADDR;
                        st_nxt.ready = 1'b0;
                        st_nxt.ad_out = req_addr; // RULE1
                        st_nxt.ad_oe = 1'b1; // RULE1
                        st_nxt.wdata = req_wdata;
                        st_nxt.rnw = req_read; // RULE7
                        st_nxt.is_rd = req_read;
                        st_nxt.burst_n = ~req_burst; // RULE10
                        st_nxt.ts_n = 1'b0; // RULE11
                        st_nxt.ale = 1'b1; // RULE12
                        st_nxt.use_lanes = (req_target == TGT_EXT) ||
                                           (req_target == TGT_PERIPH); // RULE4
                        st_nxt.lanes_hold = lane_mask_n(req_size, req_addr[1:0]);
                        st_nxt.cs_hold = (req_target == TGT_EXT) ?
                                         cs_decode_n(req_cs) : CS_NONE; // RULE14
                        st_nxt.cs_n = st_nxt.cs_hold;
                        st_nxt.lanes_n = LANES_NONE;
                    end
                end
                PH_ADDR: begin
                    // Address phase lasts one bus clock, then data phase
                    st_nxt.ph = PH_DATA;
                    st_nxt.ts_n = 1'b1;
                    st_nxt.ale = 1'b0; // RULE12
                    st_nxt.lanes_n = st_r.use_lanes ? st_r.lanes_hold : LANES_NONE; // RULE4
                    if (st_r.is_rd) begin
                        st_nxt.ad_oe = 1'b0; // RULE1
                        st_nxt.oe_n = 1'b0; // RULE5
                    end else begin
                        st_nxt.ad_out = st_r.wdata;
                    end
                end
                PH_DATA: begin
                    if (!transfer_ack_n) begin
                        st_nxt.ph = PH_END; // RULE6
                        st_nxt.rsp_v = 1'b1;
                        if (st_r.is_rd) begin
                            st_nxt.rdata = mux_addr_data_bus_in; // RULE6
                        end
                        st_nxt.cs_n = CS_NONE; // RULE16
                        st_nxt.lanes_n = LANES_NONE; // RULE16
                        st_nxt.oe_n = 1'b1; // RULE16
                        st_nxt.ad_oe = 1'b0; // RULE1
                        st_nxt.burst_n = 1'b1;
                    end
                end
                PH_END: begin
                    st_nxt.ph = PH_IDLE;
                    st_nxt.ready = 1'b1;
                    st_nxt.rnw = 1'b1;
                end
                default: st_nxt.ph = PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ph <= PH_IDLE;
            st_r.div <= DIV_RESET;
            st_r.lanes_n <= LANES_NONE; // RULE16
            st_r.lanes_hold <= LANES_NONE;
            st_r.cs_n <= CS_NONE; // RULE16
            st_r.cs_hold <= CS_NONE;
            st_r.oe_n <= 1'b1; // RULE16
            st_r.ts_n <= 1'b1; // RULE16
            st_r.burst_n <= 1'b1;
            st_r.rnw <= 1'b1;
            st_r.ready <= 1'b1;
            st_r.pw <= PW_BOOT_DEFAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign ext_bus_clk_out = st_r.bclk;
    assign mux_addr_data_bus_out = st_r.ad_out;
    assign mux_addr_data_bus_oe = st_r.ad_oe;
    assign byte_lane_select_n = st_r.lanes_n;
    assign read_drive_enable_n = st_r.oe_n;
    assign read_not_write = st_r.rnw;
    assign burst_flag_n = st_r.burst_n;
    assign transfer_start_n = st_r.ts_n;
    assign addr_latch_strobe = st_r.ale;
    assign chip_sel_n = st_r.cs_n;
    assign port_width_code = st_r.pw;
    assign req_ready = st_r.ready;
    assign rsp_valid = st_r.rsp_v;
    assign rsp_rdata = st_r.rdata;
endmodule

// >>> ext_bus_port_properties.sv
/* Pin-level checker for the external bus port.
   Assumes binding to ext_bus_port with one core clock domain. */
`timescale 1ns/1ps
module ext_bus_port_properties
    import ext_bus_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched outputs
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic ext_bus_clk_out,
    input wire logic mux_addr_data_bus_oe,
    input wire logic [3:0] byte_lane_select_n,
    input wire logic read_drive_enable_n,
    input wire logic read_not_write,
    input wire logic transfer_start_n,
    input wire logic addr_latch_strobe,
    input wire logic [3:0] chip_sel_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // One bus clock is four core clocks
    ale_one_bus_a: assert property ($rose(addr_latch_strobe) |->
        addr_latch_strobe[*4] ##1 !addr_latch_strobe) else $error("strobe width wrong");
    clk_div_a: assert property ($rose(ext_bus_clk_out) |->
        ext_bus_clk_out[*2] ##1 !ext_bus_clk_out[*2] ##1 ext_bus_clk_out) else $error("bad clk");
    // Idle means every select negated
    idle_quiet_a: assert property (req_ready |-> chip_sel_n == CS_NONE &&
        byte_lane_select_n == LANES_NONE && read_drive_enable_n && transfer_start_n)
        else $error("select active while idle");
    ts_addr_a: assert property (!transfer_start_n |->
        addr_latch_strobe && mux_addr_data_bus_oe) else $error("start outside address phase");
    oe_read_a: assert property (!read_drive_enable_n |->
        read_not_write && !mux_addr_data_bus_oe) else $error("drive enable on write");
    wr_drive_a: assert property (!read_not_write && byte_lane_select_n != LANES_NONE
        |-> mux_addr_data_bus_oe) else $error("write data not driven");
    rsp_end_a: assert property (rsp_valid |-> chip_sel_n == CS_NONE &&
        byte_lane_select_n == LANES_NONE ##1 !rsp_valid) else $error("cycle not ended");
    cs_single_a: assert property (chip_sel_n != CS_NONE |->
        $onehot(~chip_sel_n)) else $error("several chip selects");
endmodule
bind ext_bus_port ext_bus_port_properties i_props (.clk, .rst_n, .req_ready, .rsp_valid,
    .ext_bus_clk_out, .mux_addr_data_bus_oe, .byte_lane_select_n, .read_drive_enable_n,
    .read_not_write, .transfer_start_n, .addr_latch_strobe, .chip_sel_n);

// >>> ext_slave_model.sv
/* Behavioural external slave: latches the address, answers after a wait.
   Assumes pins sampled on the core clock of the port. */
`timescale 1ns/1ps
module ext_slave_model (
    // Clock
    input wire logic clk,
    // Bus pins
    input wire logic [31:0] bus_q,
    input wire logic ale,
    input wire logic oe_n,
    input wire logic rnw,
    input wire logic bclk,
    input wire logic [1:0] wait_cnt,
    output logic ack_n,
    output logic drive,
    output logic [31:0] rd_data,
    output logic [31:0] lat_addr,
    output logic [31:0] wr_data
);
    logic [2:0] cnt_r = 3'h7;
    logic bclk_r = 1'b0;
    logic ack_r = 1'b1;
    // Ack spans one bus clock only, so it never lingers into the next cycle
    assign ack_n = !(cnt_r == {1'b0, wait_cnt} + 3'h1);
    assign drive = !oe_n;
    assign rd_data = lat_addr ^ 32'h5a5a_a5a5;
    // Address capture and bus clock counting
    always_ff @(posedge clk) begin
        bclk_r <= bclk;
        ack_r <= ack_n;
        if (ale) begin
            lat_addr <= bus_q;
            cnt_r <= 3'h0;
        end else if (bclk && !bclk_r && cnt_r != 3'h7) begin
            cnt_r <= cnt_r + 3'h1;
        end
        if (!ack_n && ack_r && !rnw) begin
            wr_data <= bus_q;
        end
    end
endmodule

// >>> ext_bus_port_tb.sv
/* Self-checking bench for the external bus port.
   Assumes the slave model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module ext_bus_port_tb;
    import ext_bus_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr = 1'b0, req_valid = 1'b0, req_read = 1'b0, req_burst = 1'b0;
    logic [1:0] boot_width = PW_16, cfg_sel = 2'h0, cfg_width = 2'h0, wait_cnt = 2'h0;
    logic [1:0] req_size = SZ_BYTE, req_cs = 2'h0, req_target = TGT_EXT, pw;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, bus_in, bus_out;
    logic [31:0] rd_data, lat_addr, wr_data;
    logic req_ready, rsp_valid, ext_bus_clk_out, bus_oe, oe_n, ack_n, rnw, burst_n, ts_n;
    logic ale, drive;
    logic [3:0] lanes_n, cs_n;
    int n_errors = 0, num_checks = 0, cycles = 0;
    initial forever #2 clk = ~clk;
    // Released bus shows the inverse of the last driven value
    assign bus_in = bus_oe ? bus_out : (drive ? rd_data : ~bus_out);
    ext_bus_port i_dut (.clk, .rst_n, .boot_width, .cfg_wr, .cfg_sel, .cfg_width,
        .req_valid, .req_addr, .req_wdata, .req_read, .req_size, .req_cs, .req_target,
        .req_burst, .req_ready, .rsp_valid, .rsp_rdata, .ext_bus_clk_out,
        .mux_addr_data_bus_in(bus_in), .mux_addr_data_bus_out(bus_out),
        .mux_addr_data_bus_oe(bus_oe), .byte_lane_select_n(lanes_n),
        .read_drive_enable_n(oe_n), .transfer_ack_n(ack_n), .read_not_write(rnw),
        .port_width_code(pw), .burst_flag_n(burst_n), .transfer_start_n(ts_n),
        .addr_latch_strobe(ale), .chip_sel_n(cs_n));
    ext_slave_model i_slave (.clk, .bus_q(bus_in), .ale, .oe_n, .rnw,
        .bclk(ext_bus_clk_out), .wait_cnt, .ack_n, .drive, .rd_data, .lat_addr, .wr_data);
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic t_reset;
        `CHK({cs_n, lanes_n, oe_n, ts_n, burst_n}, {CS_NONE, LANES_NONE, 3'h7})
        `CHK({ale, bus_oe, req_ready, rnw}, 4'h3)
        $display("reset test done");
    endtask
    task automatic t_width;
        `CHK(pw, PW_16)
        // Strap moves after release; chip select 0 must keep the first value
        boot_width = PW_8;
        for (int i = 1; i < NUM_CS; i++) begin
            cfg_sel = 2'(i);
            cfg_width = 2'(i - 1);
            cfg_wr = 1'b1;
            cyc(1);
            cfg_wr = 1'b0;
            req_cs = 2'(i);
            cyc(3);
            `CHK(pw, 2'(i - 1))
        end
        req_cs = 2'h0;
        cyc(3);
        `CHK(pw, PW_16)
        $display("width test done");
    endtask
    // Fields come from the index so sizes, targets, lanes and waits all vary
    task automatic t_xfer(input int i);
        logic [3:0] mask;
        logic [31:0] a;
        int k;
        a = 32'h4000_0100 + 32'(i * 7);
        req_read = i[0];
        req_size = i % 3 == 0 ? SZ_BYTE : (i % 3 == 1 ? SZ_WORD : SZ_LONG);
        req_target = 2'(i / 3);
        req_cs = 2'(i);
        req_burst = i[2];
        wait_cnt = 2'(i);
        req_addr = a;
        req_wdata = ~a;
        // Lane 0 is the top byte, so byte offset n uses lane n
        if (req_size == SZ_BYTE) mask = 4'h1 << a[1:0];
        else if (req_size == SZ_WORD) mask = a[1] ? 4'hc : 4'h3;
        else mask = 4'hf;
        if (req_target[1]) mask = 4'h0;
        cyc(2);
        req_valid = 1'b1;
        k = 0;
        while (req_ready === 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        req_valid = 1'b0;
        `CHK({ts_n, ale, bus_oe, rnw, burst_n}, {3'h3, req_read, !req_burst})
        `CHK(bus_out, a)
        `CHK(ext_bus_clk_out, 1'b1)
        `CHK(cs_n, req_target == TGT_EXT ? ~(4'h1 << req_cs) : CS_NONE)
        cyc(4);
        `CHK({ale, lanes_n, oe_n}, {1'b0, ~mask, !req_read})
        if (!req_read) `CHK({bus_oe, bus_out}, {1'b1, ~a})
        k = 0;
        while (rsp_valid !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        `CHK(lat_addr, a)
        `CHK(req_read ? rsp_rdata : wr_data, req_read ? a ^ 32'h5a5a_a5a5 : ~a)
        `CHK({rsp_valid, cs_n}, {1'b1, CS_NONE})
        k = 0;
        while (req_ready !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        $display("transfer %0d done", i);
    endtask
    // Main sequence
    initial begin
        cyc(8);
        rst_n = 1'b1;
        cyc(4);
        t_reset();
        t_width();
        for (int i = 0; i < 12; i++) t_xfer(i);
        conclude();
    end
endmodule
